// ### logic/chb_host.sv
`timescale 1ns/1ps
`include "chb_map.svh"
module chb_host
   import chb_pkg::*;
#(
   parameter int AW = 11
) (
   // Clock and reset
   input  wire logic          mclk_in,
   input  wire logic          nrst_in,
   // User command side
   input  wire logic          req_in,
   input  wire chb_op_t       op_in,
   input  wire logic          dma_in,
   input  wire logic          ide_in,
   input  wire logic          master_in,
   input  wire logic          byte_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic          alt_in,
   input  wire logic [15:0]   wdata_in,
   output logic               busy_out,
   output logic               done_out,
   output logic [15:0]        rdata_out,
   output logic               present_out,
   output logic               input_acknowledge_n_seen_out,
   output logic               dma_pending_out,
   // Card pins
   output logic [AW-1:0]      addr_out,
   output logic [1:0]         card_enable_n_out,
   output logic               reg_n_out,
   output logic               oe_n_out,
   output logic               we_n_out,
   output logic               iord_n_out,
   output logic               iowr_n_out,
   output logic               dmack_n_out,
   output logic               ide_mode_select_n_out,
   output logic               master_slave_select_n_out,
   output logic               master_slave_select_oe_out,
   output logic [15:0]        data_out,
   output logic               data_oe_out,
   input  wire logic [15:0]   data_in,
   input  wire logic [1:0]    card_detect_n_in,
   input  wire logic          input_acknowledge_n_in,
   input  wire logic          dmarq_in
);
   localparam logic [`CHB_CNT_W-1:0] SETUP_C  = `CHB_CNT_W'(`CHB_SETUP_CYC);
   localparam logic [`CHB_CNT_W-1:0] STROBE_C = `CHB_CNT_W'(`CHB_STROBE_CYC);
   localparam logic [`CHB_CNT_W-1:0] HOLD_C   = `CHB_CNT_W'(`CHB_HOLD_CYC);

   // Synchronised pin inputs
   logic [19:0] pins_s;
   chb_sync #(.W(20)) u_sync (
      .mclk_in  (mclk_in),
      .nrst_in  (nrst_in),
      .async_in ({data_in, card_detect_n_in, input_acknowledge_n_in, dmarq_in}),
      .sync_out (pins_s)
   );
   logic [15:0] data_s;
   logic [1:0]  cd_s;
   logic        input_acknowledge_n_s;
   logic        dmarq_s;
   assign data_s   = pins_s[19:4];
   assign cd_s     = pins_s[3:2];
   assign input_acknowledge_n_s = pins_s[1];
   assign dmarq_s  = pins_s[0];

   // Enables from address bit 0 and width
   function automatic logic [1:0] enables(input logic a0, input logic bw);
      if (!bw)
         enables = 2'h0;               // Word: both low
      else if (a0)
         enables = 2'h2;               // Odd byte on low lanes via low enable
      else
         enables = 2'h2;               // Even byte via low enable
   endfunction

   // Sequencer state
   chb_state_t             st_q, st_d;
   logic [`CHB_CNT_W-1:0]  cnt_q, cnt_d;
   chb_op_t                op_q, op_d;
   logic                   dmac_q, dmac_d;     // Current cycle is DMA
   logic                   bw_q, bw_d;
   logic                   mode_ok_q, mode_ok_d;
   chb_mode_t              mode_q, mode_d;
   logic [AW-1:0]          addr_q, addr_d;
   logic [1:0]             ce_q, ce_d;
   logic                   reg_q, reg_d;
   logic                   oe_q, oe_d, we_q, we_d, iord_q, iord_d, iowr_q, iowr_d;
   logic                   dmack_q, dmack_d;
   logic [15:0]            wd_q, wd_d, rd_q, rd_d;
   logic                   doe_q, doe_d;
   logic                   done_q, done_d;
   logic                   inp_q, inp_d;
   logic                   is_rd, is_io;

   // Next state of the cycle sequencer
   always_comb begin
      st_d = st_q; cnt_d = cnt_q; op_d = op_q; dmac_d = dmac_q; bw_d = bw_q;
      mode_ok_d = 1'b1; mode_d = mode_q; addr_d = addr_q; ce_d = ce_q; reg_d = reg_q;
      oe_d = oe_q; we_d = we_q; iord_d = iord_q; iowr_d = iowr_q; dmack_d = dmack_q;
      wd_d = wd_q; rd_d = rd_q; doe_d = doe_q; done_d = 1'b0; inp_d = inp_q;
      is_rd = (op_q == CHB_OP_MEM_RD) || (op_q == CHB_OP_IO_RD) || (op_q == CHB_OP_ATTR_RD);
      is_io = (op_q == CHB_OP_IO_RD) || (op_q == CHB_OP_IO_WR);
      // Mode latched once after reset release
      if (!mode_ok_q)
         mode_d = ide_in ? CHB_MODE_IDE : CHB_MODE_IO;
      case (st_q)
         CHB_ST_IDLE: begin
            if (req_in && mode_ok_q) begin
               op_d = op_in;
               // DMA only when enabled and the card requests
               dmac_d = dma_in && dmarq_s && (mode_q == CHB_MODE_IDE);
               bw_d = byte_in && !(dma_in && mode_q == CHB_MODE_IDE);
               if (mode_q == CHB_MODE_IDE) begin
                  addr_d = AW'(addr_in[`CHB_IDE_ADDR_W-1:0]);
                  ce_d = (dma_in && dmarq_s) ? 2'h3 :
                         (alt_in ? 2'h1 : 2'h2);
               end else begin
                  addr_d = addr_in;
                  ce_d = enables(addr_in[0], byte_in);
               end
               // Attribute space low, common high, low for I/O
               reg_d = !((op_in == CHB_OP_ATTR_RD) || (op_in == CHB_OP_ATTR_WR) ||
                         (op_in == CHB_OP_IO_RD) || (op_in == CHB_OP_IO_WR));
               wd_d = wdata_in;
               inp_d = 1'b0;
               cnt_d = SETUP_C;
               st_d = CHB_ST_SETUP;
            end
         end
         CHB_ST_SETUP: begin
            if (dmac_q)
               dmack_d = 1'b0;
            doe_d = !is_rd;
            if (cnt_q <= 1) begin
               // Direction set by which strobe pulses
               if (is_io || dmac_q || mode_q == CHB_MODE_IDE) begin
                  iord_d = !is_rd;
                  iowr_d = is_rd;
               end else begin
                  oe_d = !is_rd;
                  we_d = is_rd;
               end
               cnt_d = STROBE_C;
               st_d = CHB_ST_STRB;
            end else
               cnt_d = cnt_q - 1'b1;
         end
         CHB_ST_STRB: begin
            if (!input_acknowledge_n_s && is_io && mode_q == CHB_MODE_IO)
               inp_d = 1'b1;
            if (cnt_q <= 1) begin
               if (is_rd)
                  rd_d = bw_q && addr_q[0] && mode_q != CHB_MODE_IDE ?
                         {8'h00, data_s[7:0]} : data_s;
               oe_d = 1'b1; we_d = 1'b1; iord_d = 1'b1;
               iowr_d = 1'b1;
               cnt_d = HOLD_C;
               st_d = CHB_ST_HOLD;
            end else
               cnt_d = cnt_q - 1'b1;
         end
         CHB_ST_HOLD: begin
            if (cnt_q <= 1) begin
               doe_d = 1'b0; ce_d = 2'h3; reg_d = 1'b1;
               dmack_d = 1'b1;
               st_d = CHB_ST_DONE;
            end else
               cnt_d = cnt_q - 1'b1;
         end
         default: begin
            done_d = 1'b1;
            st_d = CHB_ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= CHB_ST_IDLE; cnt_q <= '0; op_q <= CHB_OP_MEM_RD; dmac_q <= 1'b0;
         bw_q <= 1'b0; mode_ok_q <= 1'b0; mode_q <= CHB_MODE_IO; addr_q <= '0;
         ce_q <= 2'h3; reg_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1; iord_q <= 1'b1;
         iowr_q <= 1'b1; dmack_q <= 1'b1; wd_q <= 16'h0000; rd_q <= 16'h0000;
         doe_q <= 1'b0; done_q <= 1'b0; inp_q <= 1'b0;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; op_q <= op_d; dmac_q <= dmac_d;
         bw_q <= bw_d; mode_ok_q <= mode_ok_d; mode_q <= mode_d; addr_q <= addr_d;
         ce_q <= ce_d; reg_q <= reg_d; oe_q <= oe_d; we_q <= we_d; iord_q <= iord_d;
         iowr_q <= iowr_d; dmack_q <= dmack_d; wd_q <= wd_d; rd_q <= rd_d;
         doe_q <= doe_d; done_q <= done_d; inp_q <= inp_d;
      end
   end

   // Status flops
   logic pres_q, pres_d, dp_q, dp_d, msn_q, msn_d, ide_q, ide_d, busy_q, busy_d;
   always_comb begin
      pres_d = (cd_s == 2'h0);
      dp_d = dma_in && (mode_q == CHB_MODE_IDE) && dmarq_s;
      // Drive the select pin to ground only when the card is to be master
      msn_d = master_in;
      // Pin follows the latched mode, so a later change of ide_in is ignored
      ide_d = (mode_d != CHB_MODE_IDE);
      busy_d = (st_d != CHB_ST_IDLE) || !mode_ok_d;
   end
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pres_q <= 1'b0; dp_q <= 1'b0; msn_q <= 1'b0; ide_q <= 1'b1; busy_q <= 1'b1;
      end else begin
         pres_q <= pres_d; dp_q <= dp_d; msn_q <= msn_d; ide_q <= ide_d; busy_q <= busy_d;
      end
   end

   // Outputs straight from flops, except the select pin level, which is tied low
   assign busy_out = busy_q;
   assign done_out = done_q;
   assign rdata_out = rd_q;
   assign present_out = pres_q;
   assign input_acknowledge_n_seen_out = inp_q;
   assign dma_pending_out = dp_q;
   assign addr_out = addr_q;
   assign card_enable_n_out = ce_q;
   assign reg_n_out = reg_q;
   assign oe_n_out = oe_q;
   assign we_n_out = we_q;
   assign iord_n_out = iord_q;
   assign iowr_n_out = iowr_q;
   assign dmack_n_out = dmack_q;
   assign ide_mode_select_n_out = ide_q;
   assign master_slave_select_n_out = 1'b0;
   assign master_slave_select_oe_out = msn_q;   // Open when slave; card pulls up
   assign data_out = wd_q;
   assign data_oe_out = doe_q;

   // Assertions
   a_dmack_no_cs: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !dmack_q |-> ce_q == 2'h3) else $error("selects active with dma ack");
   a_one_strobe: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !(iord_q == 1'b0 && iowr_q == 1'b0)) else $error("both io strobes low");
   a_strobe_width: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      $fell(iord_q) |-> !iord_q [*4]) else $error("read strobe too short");
   a_wr_data_held: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      $rose(iowr_q) |-> doe_q) else $error("write data gone at rise");
   a_ide_addr: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      mode_q == CHB_MODE_IDE && st_q != CHB_ST_IDLE |-> addr_q[AW-1:`CHB_IDE_ADDR_W] == '0)
      else $error("high ide address lines set");
   a_mode_stable: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      mode_ok_q |=> $stable(mode_q)) else $error("mode changed after reset");
   a_reg_io_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !iord_q && mode_q == CHB_MODE_IO |-> !reg_q) else $error("reg high in io cycle");
   a_done_ends: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      done_q |-> ce_q == 2'h3 ##1 !done_q) else $error("done not single");
   c_io_read: cover property (@(posedge mclk_in) disable iff (!nrst_in) $rose(iord_q) && !dmac_q);
   c_dma: cover property (@(posedge mclk_in) disable iff (!nrst_in) $fell(dmack_q));
   c_mem_wr: cover property (@(posedge mclk_in) disable iff (!nrst_in) $fell(we_q));
endmodule

// ### common/chb_map.svh
`ifndef CHB_MAP_SVH
`define CHB_MAP_SVH
// Strobe timing in ns and derived cycle counts at 50 MHz
`define CHB_CLK_NS      20
`define CHB_SETUP_NS    70
`define CHB_STROBE_NS   170
`define CHB_HOLD_NS     30
`define CHB_SETUP_CYC   ((`CHB_SETUP_NS + `CHB_CLK_NS - 1) / `CHB_CLK_NS)
`define CHB_STROBE_CYC  ((`CHB_STROBE_NS + `CHB_CLK_NS - 1) / `CHB_CLK_NS)
`define CHB_HOLD_CYC    ((`CHB_HOLD_NS + `CHB_CLK_NS - 1) / `CHB_CLK_NS)
`define CHB_CNT_W       4
// IDE task file address width
`define CHB_IDE_ADDR_W  3
`endif

// ### common/chb_pkg.sv
package chb_pkg;
   // Bus cycle kinds requested by the user side
   typedef enum logic [2:0] {
      CHB_OP_MEM_RD  = 3'h0,
      CHB_OP_MEM_WR  = 3'h1,
      CHB_OP_IO_RD   = 3'h2,
      CHB_OP_IO_WR   = 3'h3,
      CHB_OP_ATTR_RD = 3'h4,
      CHB_OP_ATTR_WR = 3'h5
   } chb_op_t;
   // Interface mode of the card
   typedef enum logic [1:0] {
      CHB_MODE_MEM = 2'h0,
      CHB_MODE_IO  = 2'h1,
      CHB_MODE_IDE = 2'h2
   } chb_mode_t;
   // Cycle sequencer states
   typedef enum logic [2:0] {
      CHB_ST_IDLE  = 3'h0,
      CHB_ST_SETUP = 3'h1,
      CHB_ST_STRB  = 3'h2,
      CHB_ST_HOLD  = 3'h3,
      CHB_ST_DONE  = 3'h4
   } chb_state_t;
endpackage

// ### logic/chb_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser bank for pin inputs
module chb_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk_in,
   input  wire logic         nrst_in,
   // Asynchronous level in, synchronised level out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;   // First stage, read only by second
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;   // Second stage
   logic [W-1:0] sync_d;
   // Next values
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end
   // Registers, pins idle high
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_out = sync_q;
endmodule

// ### dv/chb_card_model.sv
`timescale 1ns/1ps
// Behavioural card: byte store per space, strobe driven, no clock
module chb_card_model #(
   parameter int AW = 11
) (
   // Host pins seen by the card
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [1:0]    card_enable_n_in,
   input  wire logic          reg_n_in,
   input  wire logic          oe_n_in,
   input  wire logic          we_n_in,
   input  wire logic          iord_n_in,
   input  wire logic          iowr_n_in,
   input  wire logic          dmack_n_in,
   input  wire logic          ide_mode_select_n_in,
   input  wire logic          master_slave_select_n_in,
   input  wire logic [15:0]   bus_in,
   // Card outputs
   output logic [15:0]        data_out,
   output logic [1:0]         card_detect_n_out,
   output logic               input_acknowledge_n_out,
   output logic               dmarq_out
);
   logic [7:0]  mem [int];         // Byte store keyed by space and address
   int          dma_left = 0;      // Words left to move, loaded by the bench
   logic [15:0] last_q   = 16'h0;  // Last value driven on the lanes
   logic        drq_last = 1'b0;   // Last request level driven
   logic        ide;               // IDE mode chosen by the host
   logic        dma;               // DMA word cycle in progress
   logic        rd;                // Card drives the lanes
   logic [15:0] rd_val;            // Value presented on a read
   assign card_detect_n_out = 2'h0;
   assign ide = !ide_mode_select_n_in;
   // Ack counts only with words pending and both selects off
   assign dma = ide && dma_left > 0 && !dmack_n_in && (&card_enable_n_in);
   assign input_acknowledge_n_out = !(!ide && !(&card_enable_n_in) && !iord_n_in && !reg_n_in);
   function automatic int key(input int sp, input int a);
      return (sp << 16) | a;
   endfunction
   function automatic logic [7:0] rb(input int k);
      return mem.exists(k) ? mem[k] : 8'hff;
   endfunction
   // Space of the cycle: task file, I/O or attribute
   function automatic int sp_addr(input logic io);
      if (ide) return key(3, {28'h0, ~card_enable_n_in[1], addr_in[2:0]});
      return key(io ? 2 : 1, int'(addr_in));
   endfunction
   // Read path with byte steering onto the lanes
   always @* begin
      rd = 1'b0;
      rd_val = last_q;
      if (dma && !iord_n_in) begin
         rd = 1'b1;
         rd_val = {rb(key(4, 1)), rb(key(4, 0))};
      end else if (!(&card_enable_n_in) && (!iord_n_in || (!oe_n_in && !reg_n_in && !ide))) begin
         rd = 1'b1;
         if (ide) rd_val = {8'h00, rb(sp_addr(1'b1))};
         else if (card_enable_n_in == 2'b00)
            rd_val = {rb(sp_addr(!iord_n_in) | 1), rb(sp_addr(!iord_n_in) & ~1)};
         else if (card_enable_n_in == 2'b10) rd_val = {8'h00, rb(sp_addr(!iord_n_in))};
         else rd_val = {rb(sp_addr(!iord_n_in) | 1), 8'h00};
      end
   end
   // Released lanes show the inverse of the last value
   always @* if (rd) last_q = rd_val;
   assign data_out = rd ? rd_val : ~last_q;
   // Write data taken on the rising strobe edge
   task automatic wr(input logic io);
      int k;
      k = sp_addr(io);
      if (dma && io) begin
         mem[key(4, 0)] = bus_in[7:0];
         mem[key(4, 1)] = bus_in[15:8];
      end else if (!(&card_enable_n_in) && (io || (!reg_n_in && !ide))) begin
         if (ide || card_enable_n_in == 2'b10) mem[k] = bus_in[7:0];
         else if (card_enable_n_in == 2'b01) mem[k | 1] = bus_in[15:8];
         else begin
            mem[k & ~1] = bus_in[7:0];
            mem[k | 1] = bus_in[15:8];
         end
      end
   endtask
   always @(posedge iowr_n_in) wr(1'b1);
   always @(posedge we_n_in) wr(1'b0);
   // One word done at the end of each acknowledge
   always @(posedge dmack_n_in) if (ide && dma_left > 0) dma_left--;
   // Request driven only by the master, dropped while acknowledged
   always @* begin
      if (ide && master_slave_select_n_in == 1'b0) begin
         dmarq_out = dma_left > 0 && dmack_n_in;
         drq_last = dmarq_out;
      end else dmarq_out = ~drq_last;
   end
endmodule

// ### dv/chb_host_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module chb_host_tb;
   import chb_pkg::*;
   localparam int AW = 11;
   logic mclk = 1'b0, nrst = 1'b0, req = 1'b0, dma = 1'b0, ide = 1'b0, master = 1'b0, byte_en = 1'b0, alt = 1'b0;
   chb_op_t op = CHB_OP_MEM_RD;
   logic [AW-1:0] addr = '0, p_addr;
   logic [15:0] wdata = 16'h0, rdata, h_data, c_data;
   logic busy, done, present, input_acknowledge_n_seen, dma_pending, p_reg_n, p_oe_n, p_we_n, p_iord_n, p_iowr_n;
   logic p_dmack_n, p_ide_n, p_msel_n, p_msel_oe, h_oe, c_input_acknowledge_n_n, c_drq, saw_ack = 1'b0;
   logic [1:0] p_ce_n, c_cd_n;
   wire [15:0] bus = h_oe ? h_data : c_data;  // Resolved data lanes
   wire        msel = p_msel_oe ? p_msel_n : 1'b1;  // Weak pull-up on the card
   int n_mismatch = 0, check_count = 0;
   logic [31:0] seed = 32'h0000f2ac;  // 62124
   logic [7:0] ref_b [int];  // Expected card contents
   always #10 mclk = ~mclk;
   always @(negedge p_dmack_n) saw_ack = 1'b1;
   chb_host #(.AW(AW)) chb_host_inst (.mclk_in(mclk), .nrst_in(nrst), .req_in(req), .op_in(op), .dma_in(dma),
      .ide_in(ide), .master_in(master), .byte_in(byte_en), .addr_in(addr), .alt_in(alt), .wdata_in(wdata),
      .busy_out(busy), .done_out(done), .rdata_out(rdata), .present_out(present), .input_acknowledge_n_seen_out(input_acknowledge_n_seen),
      .dma_pending_out(dma_pending), .addr_out(p_addr), .card_enable_n_out(p_ce_n), .reg_n_out(p_reg_n),
      .oe_n_out(p_oe_n), .we_n_out(p_we_n), .iord_n_out(p_iord_n), .iowr_n_out(p_iowr_n), .dmack_n_out(p_dmack_n),
      .ide_mode_select_n_out(p_ide_n), .master_slave_select_n_out(p_msel_n),
      .master_slave_select_oe_out(p_msel_oe), .data_out(h_data), .data_oe_out(h_oe), .data_in(bus),
      .card_detect_n_in(c_cd_n), .input_acknowledge_n_in(c_input_acknowledge_n_n), .dmarq_in(c_drq));
   chb_card_model #(.AW(AW)) chb_card_model_inst (.addr_in(p_addr), .card_enable_n_in(p_ce_n),
      .reg_n_in(p_reg_n), .oe_n_in(p_oe_n), .we_n_in(p_we_n), .iord_n_in(p_iord_n), .iowr_n_in(p_iowr_n),
      .dmack_n_in(p_dmack_n), .ide_mode_select_n_in(p_ide_n), .master_slave_select_n_in(msel), .bus_in(bus),
      .data_out(c_data), .card_detect_n_out(c_cd_n), .input_acknowledge_n_out(c_input_acknowledge_n_n), .dmarq_out(c_drq));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected read value from the reference contents
   function automatic logic [15:0] exp_rd(input int sp, input int a, input logic byt);
      if (byt) return {8'h00, ref_b[(sp << 16) | a]};
      return {ref_b[(sp << 16) | a | 1], ref_b[(sp << 16) | (a & ~1)]};
   endfunction
   task automatic put(input int sp, input int a, input logic byt, input logic [15:0] d);
      if (byt) ref_b[(sp << 16) | a] = d[7:0];
      else {ref_b[(sp << 16) | a | 1], ref_b[(sp << 16) | (a & ~1)]} = d;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One user request, held until taken, bounded wait for done
   task automatic run_op(input chb_op_t o, input int a, input logic byt, input logic al, input logic [15:0] d);
      int n;
      @(negedge mclk);
      op = o; addr = AW'(a); byte_en = byt; alt = al; wdata = d; req = 1'b1;
      for (n = 0; n < 40 && done !== 1'b1; n++) begin
         @(negedge mclk);
         if (busy === 1'b1) req = 1'b0;
      end
      `CHK("done", 1'b1, done);
   endtask
   task automatic do_reset(input logic i, input logic m, input logic dm);
      @(negedge mclk);
      nrst = 1'b0; ide = i; master = m; dma = dm; req = 1'b0;
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      `CHK("present", 1'b1, present);
      `CHK("ide_pin", !i, p_ide_n);
      if (i) `CHK("msel_oe", m, p_msel_oe);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #(20 * 20000);
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen timeout");
      wrap_up();
   end
   initial begin
      logic [15:0] d;
      int a, k;
      do_reset(1'b0, 1'b0, 1'b0);
      ide = 1'b1;
      repeat (3) @(negedge mclk);
      `CHK("mode_kept_io", 1'b1, p_ide_n);
      ide = 1'b0;
      for (k = 0; k < 6; k++) begin
         a = int'(rnd() & 32'h7fe); d = rnd();
         run_op(CHB_OP_IO_WR, a, 1'b0, 1'b0, d); put(2, a, 1'b0, d);
         run_op(CHB_OP_IO_RD, a, 1'b0, 1'b0, 16'h0);
         `CHK("io_word", exp_rd(2, a, 1'b0), rdata);
         `CHK("input_acknowledge_n_io", 1'b1, input_acknowledge_n_seen);
         run_op(CHB_OP_IO_RD, a | 1, 1'b1, 1'b0, 16'h0);
         `CHK("io_odd_byte", 8'(exp_rd(2, a | 1, 1'b1)), rdata[7:0]);
         d = rnd();
         run_op(CHB_OP_IO_WR, a | 1, 1'b1, 1'b0, d); put(2, a | 1, 1'b1, d);
         run_op(CHB_OP_IO_RD, a, 1'b0, 1'b0, 16'h0);
         `CHK("io_byte_wr", exp_rd(2, a, 1'b0), rdata);
         d = rnd();
         run_op(CHB_OP_ATTR_WR, a, 1'b0, 1'b0, d); put(1, a, 1'b0, d);
         run_op(CHB_OP_ATTR_RD, a, 1'b0, 1'b0, 16'h0);
         `CHK("attr_word", exp_rd(1, a, 1'b0), rdata);
         `CHK("input_acknowledge_n_attr", 1'b0, input_acknowledge_n_seen);
         run_op(CHB_OP_MEM_RD, a, 1'b0, 1'b0, 16'h0);
         `CHK("mem_ignored", 16'(~exp_rd(1, a, 1'b0)), rdata);
      end
      $display("test io_mode done");
      do_reset(1'b1, 1'b0, 1'b0);
      do_reset(1'b1, 1'b1, 1'b0);
      ide = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("mode_kept", 1'b0, p_ide_n);
      for (k = 0; k < 9; k++) begin
         d = rnd();
         run_op(CHB_OP_IO_WR, (k == 8) ? 6 : k, 1'b0, k == 8, d); put(3, (k == 8) ? 14 : k, 1'b1, d);
      end
      for (k = 0; k < 9; k++) begin
         run_op(CHB_OP_IO_RD, (k == 8) ? 6 : k, 1'b0, k == 8, 16'h0);
         `CHK("task_reg", 8'(exp_rd(3, (k == 8) ? 14 : k, 1'b1)), rdata[7:0]);
      end
      saw_ack = 1'b0; chb_card_model_inst.dma_left = 1;
      run_op(CHB_OP_IO_RD, 3, 1'b0, 1'b0, 16'h0);
      `CHK("no_dma_data", 8'(exp_rd(3, 3, 1'b1)), rdata[7:0]);
      `CHK("no_dma_ack", 1'b0, saw_ack);
      chb_card_model_inst.dma_left = 0;
      $display("test ide_task done");
      do_reset(1'b1, 1'b1, 1'b1);
      chb_card_model_inst.dma_left = 2; saw_ack = 1'b0; d = rnd();
      for (k = 0; k < 20 && dma_pending !== 1'b1; k++) @(negedge mclk);
      `CHK("dma_req", 1'b1, dma_pending);
      run_op(CHB_OP_IO_WR, 0, 1'b0, 1'b0, d);
      `CHK("dma_ack", 1'b1, saw_ack);
      `CHK("dma_left", 1, chb_card_model_inst.dma_left);
      for (k = 0; k < 20 && dma_pending !== 1'b1; k++) @(negedge mclk);
      run_op(CHB_OP_IO_RD, 0, 1'b0, 1'b0, 16'h0);
      `CHK("dma_word", d, rdata);
      repeat (6) @(negedge mclk);
      `CHK("dma_idle", 1'b0, dma_pending);
      $display("test ide_dma done");
      wrap_up();
   end
endmodule
